/* File: rtl/sbc_bridge_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - Port select low: stand-alone, pins repurposed.
// - Stand-alone forces both current codes full scale.
// - Bridge A mixed decay on while input low.
// - Bridge B mixed decay on while input low.
// - Polarity A low drives out 1 to 2.
// - Polarity B low drives out 1 to 2.
// - Fault output high on overcurrent or overtemperature.
// - Fault output always driven in stand-alone mode.
// - Standby high keeps bridges off, low power.
// - Standby high clears all latched errors.
// - Unipolar chops one upper transistor per polarity.
// - Unipolar decay turns both upper transistors off.
// - Unipolar ignores the mixed decay inputs.
// - High-side comparator trip flags overcurrent.
// - All-ones current code gives full-scale trip.
// - Bridges start on opposite chopper clock edges.
// - Overcurrent ends cycle; third one holds 63 cycles.
// - Overcurrent ignored during blanking after switching.
// - Polarity change restarts that bridge's cycle.
// - Slow: both lows on; fast: opposite low.
module sbc_bridge_ctrl
  import sbc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Mode and configuration
  input wire logic serial_port_select,
  input wire logic unipolar_mode,
  input wire logic osc_external,
  input wire logic [1:0] blank_sel,
  // Stand-alone control pins
  input wire logic polarity_a,
  input wire logic polarity_b,
  input wire logic mixed_decay_a_enable_n,
  input wire logic mixed_decay_b_enable_n,
  input wire logic standby_request,
  // Values from the serial interface when it is in use
  input wire logic serial_polarity_a,
  input wire logic serial_polarity_b,
  input wire logic serial_mixed_decay_a,
  input wire logic serial_mixed_decay_b,
  input wire logic [3:0] serial_dac_a,
  input wire logic [3:0] serial_dac_b,
  // Chopper clock from outside
  input wire logic chop_clk_ext,
  // Analog comparators
  input wire logic sense_trip_a,
  input wire logic sense_trip_b,
  input wire logic low_side_oc_a,
  input wire logic low_side_oc_b,
  input wire logic high_side_oc,
  input wire logic over_temp,
  // Current codes to the DACs
  output logic [3:0] dac_code_a,
  output logic [3:0] dac_code_b,
  // Bridge A gates
  output logic coil_a_out_1_high,
  output logic coil_a_out_1_low,
  output logic coil_a_out_2_high,
  output logic coil_a_out_2_low,
  // Bridge B gates
  output logic coil_b_out_1_high,
  output logic coil_b_out_1_low,
  output logic coil_b_out_2_high,
  output logic coil_b_out_2_low,
  // Fault pin and status
  output logic fault_out,
  output logic fault_oe,
  output logic serial_disable,
  output logic standby_active,
  output logic [2:0] oc_flags
);

  // Maps a chopper state to the gate word of one bridge.
  function automatic logic [3:0] gate_map(input sbc_chop_t st, input logic pol, input logic uni);
    logic [3:0] g;
    g = GATE_OFF;
    case (st)
      ST_ON: begin
        if (uni) begin
          g = pol ? GATE_UNI_REV : GATE_UNI_FWD;
        end else begin
          g = pol ? GATE_REV : GATE_FWD;
        end
      end
      ST_FAST: begin
        if (uni) begin
          g = GATE_OFF;
        end else begin
          g = pol ? GATE_FAST_REV : GATE_FAST_FWD;
        end
      end
      ST_SLOW: begin
        g = uni ? GATE_OFF : GATE_SLOW;
      end
      default: begin
        g = GATE_OFF;
      end
    endcase
    return g;
  endfunction : gate_map

  // Synchronised control inputs.
  logic [5:0] sync_q;
  logic pol_a_s;
  logic pol_b_s;
  logic md_a_n_s;
  logic md_b_n_s;
  logic standby_s;
  logic ext_clk_s;

  sbc_sync2 #(
    .W(6)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({chop_clk_ext, standby_request, mixed_decay_b_enable_n,
               mixed_decay_a_enable_n, polarity_b, polarity_a}),
    .sync_out(sync_q)
  );

  assign pol_a_s = sync_q[0];
  assign pol_b_s = sync_q[1];
  assign md_a_n_s = sync_q[2];
  assign md_b_n_s = sync_q[3];
  assign standby_s = sync_q[4];
  assign ext_clk_s = sync_q[5];

  // Mode selection; the serial pins take over their stand-alone roles here.
  wire stand_alone = ~serial_port_select;
  wire [1:0] pol_v = stand_alone ? {pol_b_s, pol_a_s} : {serial_polarity_b, serial_polarity_a};
  wire md_a = stand_alone ? ~md_a_n_s : serial_mixed_decay_a;
  wire md_b = stand_alone ? ~md_b_n_s : serial_mixed_decay_b;
  wire [1:0] md_v = unipolar_mode ? 2'b00 : {md_b, md_a};
  wire [1:0] trip_v = {sense_trip_b, sense_trip_a};
  wire [1:0] loc_v = {low_side_oc_b, low_side_oc_a};

  wire [5:0] blank_cyc = (blank_sel == 2'h0) ? BLANK_CYC_0 :
                         (blank_sel == 2'h1) ? BLANK_CYC_1 :
                         (blank_sel == 2'h2) ? BLANK_CYC_2 : BLANK_CYC_3;

  // Internal chopper oscillator and edge detection.
  logic [10:0] osc_cnt;
  logic osc_clk;
  logic chop_prev;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      osc_cnt <= 11'h000;
      osc_clk <= 1'b0;
    end else if (osc_cnt == CHOP_HALF_CYC - 11'h001) begin
      osc_cnt <= 11'h000;
      osc_clk <= ~osc_clk;
    end else begin
      osc_cnt <= osc_cnt + 11'h001;
    end
  end

  wire chop_lvl = osc_external ? ext_clk_s : osc_clk;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chop_prev <= 1'b0;
    end else begin
      chop_prev <= chop_lvl;
    end
  end

  // Bridge A starts on the rising edge, bridge B on the falling edge.
  wire [1:0] cyc_start = {~chop_lvl & chop_prev, chop_lvl & ~chop_prev};

  // Shared state between the bridges and the error channels.
  wire [1:0] blanking;
  wire [1:0] conducting;
  wire [2:0] oc_ev;
  wire [2:0] hold_act;
  wire [2:0] flag_v;
  wire [2:0] err_tick = {cyc_start[0], cyc_start};
  wire common_halt = standby_s | over_temp;

  // The high side blank time is the OR of both bridges.
  assign oc_ev[2] = high_side_oc & ~(|blanking) & (|conducting) & ~common_halt & ~hold_act[2];

  // Error channels: 0 and 1 are the low side bridges, 2 is the high side.
  for (genvar c = 0; c < 3; c++) begin : g_err
    logic [1:0] cnt;
    logic [5:0] hold;
    logic [6:0] quiet;
    logic flag;

    always_ff @(posedge mclk) begin
      if (sys_rst || standby_s) begin
        cnt <= 2'h0;
        hold <= 6'h00;
        quiet <= 7'h00;
        flag <= 1'b0;
      end else if (oc_ev[c]) begin
        quiet <= 7'h00;
        if (cnt == OC_LIMIT - 2'h1) begin
          cnt <= 2'h0;
          hold <= OC_HOLD_CYCLES;
          flag <= 1'b1;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end else if (err_tick[c]) begin
        if (hold != 6'h00) begin
          hold <= hold - 6'h01;
        end
        if (quiet == OC_QUIET_LIMIT) begin
          cnt <= 2'h0;
        end else begin
          quiet <= quiet + 7'h01;
        end
      end
    end

    assign hold_act[c] = hold != 6'h00;
    assign flag_v[c] = flag;
  end

  // Per-bridge chopper.
  logic [3:0] gates_a;
  logic [3:0] gates_b;

  for (genvar i = 0; i < 2; i++) begin : g_br
    sbc_chop_t state;
    sbc_chop_t next_state;
    logic [10:0] on_cnt;
    logic [10:0] dec_cnt;
    logic [5:0] blank_cnt;
    logic pol_prev;
    logic [3:0] gates;

    wire halted = common_halt | hold_act[i] | hold_act[2];
    wire pol_chg = pol_v[i] != pol_prev;
    wire restart = cyc_start[i] | pol_chg;
    wire kill = oc_ev[i] | oc_ev[2];
    wire [10:0] fast_len = (FAST_BASE_CYC > on_cnt) ? FAST_BASE_CYC - on_cnt : 11'h000;

    assign blanking[i] = blank_cnt != 6'h00;
    assign conducting[i] = (state == ST_ON) || (state == ST_FAST) || (state == ST_SLOW);
    assign oc_ev[i] = loc_v[i] & ~blanking[i] & conducting[i] & ~halted;

    always_comb begin
      next_state = state;
      if (halted) begin
        next_state = ST_OFF;
      end else if (kill) begin
        next_state = ST_TRIPPED;
      end else if (restart) begin
        next_state = ST_ON;
      end else begin
        case (state)
          ST_ON: begin
            if (!blanking[i] && trip_v[i]) begin
              next_state = md_v[i] ? ST_FAST : ST_SLOW;
            end
          end
          ST_FAST: begin
            if (dec_cnt >= fast_len) begin
              next_state = ST_SLOW;
            end
          end
          ST_SLOW, ST_TRIPPED, ST_OFF: begin
            next_state = state;
          end
          default: begin
            next_state = ST_OFF;
          end
        endcase
      end
    end

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        state <= ST_OFF;
        pol_prev <= 1'b0;
        blank_cnt <= 6'h00;
      end else begin
        state <= next_state;
        pol_prev <= pol_v[i];
        blank_cnt <= (next_state != state) ? blank_cyc : (blanking[i] ? blank_cnt - 6'h01 : 6'h00);
      end
    end

    // On time shortens the following fast decay phase.
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        on_cnt <= 11'h000;
        dec_cnt <= 11'h000;
      end else begin
        if (next_state == ST_ON && state != ST_ON) begin
          on_cnt <= 11'h000;
        end else if (state == ST_ON && on_cnt != 11'h7ff) begin
          on_cnt <= on_cnt + 11'h001;
        end
        dec_cnt <= (state == ST_FAST) ? dec_cnt + 11'h001 : 11'h000;
      end
    end

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        gates <= GATE_OFF;
      end else begin
        gates <= gate_map(next_state, pol_v[i], unipolar_mode);
      end
    end
  end

  assign gates_a = g_br[0].gates;
  assign gates_b = g_br[1].gates;

  assign coil_a_out_1_high = gates_a[3];
  assign coil_a_out_1_low = gates_a[2];
  assign coil_a_out_2_high = gates_a[1];
  assign coil_a_out_2_low = gates_a[0];
  assign coil_b_out_1_high = gates_b[3];
  assign coil_b_out_1_low = gates_b[2];
  assign coil_b_out_2_high = gates_b[1];
  assign coil_b_out_2_low = gates_b[0];

  // Registered outputs to the DACs and the fault pin.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dac_code_a <= DAC_FULL_SCALE;
      dac_code_b <= DAC_FULL_SCALE;
      fault_out <= 1'b0;
      fault_oe <= 1'b0;
      serial_disable <= 1'b0;
      standby_active <= 1'b0;
      oc_flags <= 3'h0;
    end else begin
      dac_code_a <= stand_alone ? DAC_FULL_SCALE : serial_dac_a;
      dac_code_b <= stand_alone ? DAC_FULL_SCALE : serial_dac_b;
      fault_out <= (|flag_v) | over_temp;
      fault_oe <= stand_alone;
      serial_disable <= stand_alone;
      standby_active <= standby_s;
      oc_flags <= flag_v;
    end
  end

endmodule : sbc_bridge_ctrl

/* File: shared/sbc_pkg.sv */
package sbc_pkg;

  // Clock and chopper timing.
  localparam int unsigned MCLK_HZ = 25_000_000;
  localparam int unsigned MCLK_PERIOD_NS = 1_000_000_000 / MCLK_HZ;
  localparam int unsigned CHOP_HZ = 25_000;
  localparam int unsigned CHOP_MAX_HZ = 100_000;
  localparam logic [10:0] CHOP_HALF_CYC = 11'(MCLK_HZ / (2 * CHOP_HZ));

  // Blank times, least times, so rounded up to whole clock cycles.
  localparam int unsigned BLANK_NS_0 = 600;
  localparam int unsigned BLANK_NS_1 = 900;
  localparam int unsigned BLANK_NS_2 = 1200;
  localparam int unsigned BLANK_NS_3 = 1500;
  localparam logic [5:0] BLANK_CYC_0 = 6'((BLANK_NS_0 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [5:0] BLANK_CYC_1 = 6'((BLANK_NS_1 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [5:0] BLANK_CYC_2 = 6'((BLANK_NS_2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [5:0] BLANK_CYC_3 = 6'((BLANK_NS_3 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

  // Base length of the fast decay phase, shortened by the on time.
  localparam int unsigned FAST_BASE_NS = 10_000;
  localparam logic [10:0] FAST_BASE_CYC = 11'(FAST_BASE_NS / MCLK_PERIOD_NS);

  // Current code and overcurrent handling.
  localparam logic [3:0] DAC_FULL_SCALE = 4'hf;
  localparam logic [1:0] OC_LIMIT = 2'h3;
  localparam logic [5:0] OC_HOLD_CYCLES = 6'h3f;
  localparam logic [6:0] OC_QUIET_LIMIT = 7'h40;

  // Gate word layout {high_1, low_1, high_2, low_2}.
  localparam logic [3:0] GATE_OFF = 4'h0;
  localparam logic [3:0] GATE_FWD = 4'h9;
  localparam logic [3:0] GATE_REV = 4'h6;
  localparam logic [3:0] GATE_UNI_FWD = 4'h8;
  localparam logic [3:0] GATE_UNI_REV = 4'h2;
  localparam logic [3:0] GATE_SLOW = 4'h5;
  localparam logic [3:0] GATE_FAST_FWD = 4'h4;
  localparam logic [3:0] GATE_FAST_REV = 4'h1;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_ON = 3'b001,
    ST_FAST = 3'b010,
    ST_SLOW = 3'b011,
    ST_TRIPPED = 3'b100
  } sbc_chop_t;

endpackage : sbc_pkg

/* File: rtl/sbc_sync2.sv */
`timescale 1ns/1ps
module sbc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : sbc_sync2

/* File: dv/sbc_host_model.sv */
`timescale 1ns/1ps
module sbc_host_model (
  // Clock and commands
  input wire logic mclk,
  input wire logic chop_run,
  input wire logic [5:0] cmd,
  // Control pins
  output logic polarity_a,
  output logic polarity_b,
  output logic mixed_decay_a_enable_n,
  output logic mixed_decay_b_enable_n,
  output logic standby_request,
  output logic serial_port_select,
  // Chopper clock
  output logic chop_clk_ext
);
  logic [6:0] half_cnt = 7'h0;

  initial begin
    {serial_port_select, standby_request, mixed_decay_b_enable_n} = 3'h0;
    {mixed_decay_a_enable_n, polarity_b, polarity_a, chop_clk_ext} = 4'h0;
  end

  // The chopper clock stands still unless running; 125 cycles a half gives 100 kHz.
  always @(posedge mclk) begin
    serial_port_select <= cmd[5];
    {standby_request, mixed_decay_b_enable_n, mixed_decay_a_enable_n, polarity_b, polarity_a} <= cmd[4:0];
    if (chop_run && half_cnt == 7'h7c) begin
      half_cnt <= 7'h0;
      chop_clk_ext <= ~chop_clk_ext;
    end else if (chop_run) begin
      half_cnt <= half_cnt + 7'h1;
    end
  end
endmodule : sbc_host_model

/* File: dv/sbc_bridge_ctrl_chk.sv */
`timescale 1ns/1ps
module sbc_bridge_ctrl_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Inputs
  input wire logic serial_port_select,
  input wire logic unipolar_mode,
  input wire logic polarity_a,
  input wire logic polarity_b,
  input wire logic over_temp,
  // Outputs
  input wire logic [3:0] dac_code_a,
  input wire logic [3:0] dac_code_b,
  input wire logic coil_a_out_1_high,
  input wire logic coil_a_out_1_low,
  input wire logic coil_a_out_2_high,
  input wire logic coil_a_out_2_low,
  input wire logic coil_b_out_1_high,
  input wire logic coil_b_out_1_low,
  input wire logic coil_b_out_2_high,
  input wire logic coil_b_out_2_low,
  input wire logic fault_out,
  input wire logic fault_oe,
  input wire logic serial_disable,
  input wire logic standby_active,
  input wire logic [2:0] oc_flags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_dac_full: assert property (!serial_port_select |=> dac_code_a == 4'hf && dac_code_b == 4'hf)
    else $error("current code not full scale");
  chk_fault_driven: assert property (!serial_port_select |=> fault_oe)
    else $error("fault pin not driven");
  chk_serial_off: assert property (!serial_port_select |=> serial_disable)
    else $error("serial port not disabled");
  chk_fault_cause: assert property (1'b1 |=> fault_out == (oc_flags != 3'h0 || $past(over_temp)))
    else $error("fault output wrong");
  chk_standby_off: assert property (standby_active |-> {coil_a_out_1_high, coil_a_out_1_low,
    coil_a_out_2_high, coil_a_out_2_low, coil_b_out_1_high, coil_b_out_1_low, coil_b_out_2_high,
    coil_b_out_2_low} == 8'h0)
    else $error("bridge on in standby");
  chk_standby_clear: assert property (standby_active |=> oc_flags == 3'h0)
    else $error("flags kept in standby");
  chk_uni_upper: assert property (unipolar_mode && $past(unipolar_mode) |-> !coil_a_out_1_low &&
    !coil_a_out_2_low && !(coil_a_out_1_high && coil_a_out_2_high))
    else $error("unipolar gate misuse");
  chk_pol_a_dir: assert property (coil_a_out_1_high && !$past(serial_port_select) |-> !$past(polarity_a, 3))
    else $error("bridge a direction wrong");
  chk_pol_b_dir: assert property (coil_b_out_2_high && !$past(serial_port_select) |-> $past(polarity_b, 3))
    else $error("bridge b direction wrong");

  cover property (standby_active && oc_flags == 3'h0);
  cover property ($rose(oc_flags[2]));
  cover property (unipolar_mode && coil_a_out_2_high);
endmodule : sbc_bridge_ctrl_chk

bind sbc_bridge_ctrl sbc_bridge_ctrl_chk chk (.mclk, .sys_rst, .serial_port_select, .unipolar_mode, .polarity_a,
  .polarity_b, .over_temp, .dac_code_a, .dac_code_b, .coil_a_out_1_high, .coil_a_out_1_low, .coil_a_out_2_high,
  .coil_a_out_2_low, .coil_b_out_1_high, .coil_b_out_1_low, .coil_b_out_2_high, .coil_b_out_2_low, .fault_out,
  .fault_oe, .serial_disable, .standby_active, .oc_flags);

/* File: dv/test_sbc_bridge_ctrl.sv */
`timescale 1ns/1ps
module test_sbc_bridge_ctrl import sbc_pkg::*;;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic unipolar_mode = 1'b0;
  logic chop_run = 1'b0;
  logic over_temp = 1'b0;
  logic [1:0] blank_sel = 2'h0;
  logic [1:0] st = 2'h0;
  logic [2:0] oc = 3'h0;
  logic [3:0] sdac = 4'h0;
  // Host command {port select, standby, decay b, decay a, polarity b, polarity a}.
  logic [5:0] cmd = 6'h0;
  logic polarity_a, polarity_b, mixed_decay_a_enable_n, mixed_decay_b_enable_n;
  logic standby_request, serial_port_select, chop_clk_ext;
  logic [3:0] dac_code_a, dac_code_b, ga_p, gb_p;
  logic coil_a_out_1_high, coil_a_out_1_low, coil_a_out_2_high, coil_a_out_2_low;
  logic coil_b_out_1_high, coil_b_out_1_low, coil_b_out_2_high, coil_b_out_2_low;
  logic fault_out, fault_oe, serial_disable, standby_active;
  logic [2:0] oc_flags;
  int failures = 0;
  int comparisons = 0;
  logic osc_external = 1'b1;
  int t_a = -1;
  int exp_q[$];
  int exp_w;
  wire [3:0] ga = {coil_a_out_1_high, coil_a_out_1_low, coil_a_out_2_high, coil_a_out_2_low};
  wire [3:0] gb = {coil_b_out_1_high, coil_b_out_1_low, coil_b_out_2_high, coil_b_out_2_low};

  always #20 mclk = ~mclk;

  sbc_host_model host (.mclk, .chop_run, .cmd, .polarity_a, .polarity_b, .mixed_decay_a_enable_n,
    .mixed_decay_b_enable_n, .standby_request, .serial_port_select, .chop_clk_ext);

  sbc_bridge_ctrl dut (.mclk, .sys_rst, .serial_port_select, .unipolar_mode, .osc_external, .blank_sel,
    .polarity_a, .polarity_b, .mixed_decay_a_enable_n, .mixed_decay_b_enable_n, .standby_request,
    .serial_polarity_a(polarity_a), .serial_polarity_b(polarity_b), .serial_mixed_decay_a(~mixed_decay_a_enable_n),
    .serial_mixed_decay_b(~mixed_decay_b_enable_n),
    .serial_dac_a(sdac), .serial_dac_b(~sdac), .chop_clk_ext, .sense_trip_a(st[0]), .sense_trip_b(st[1]),
    .low_side_oc_a(oc[0]), .low_side_oc_b(oc[1]), .high_side_oc(oc[2]), .over_temp, .dac_code_a, .dac_code_b,
    .coil_a_out_1_high, .coil_a_out_1_low, .coil_a_out_2_high, .coil_a_out_2_low, .coil_b_out_1_high,
    .coil_b_out_1_low, .coil_b_out_2_high, .coil_b_out_2_low, .fault_out, .fault_oe, .serial_disable,
    .standby_active, .oc_flags);

  function automatic logic [3:0] on_w(input logic u, input logic p);
    return u ? (p ? GATE_UNI_REV : GATE_UNI_FWD) : (p ? GATE_REV : GATE_FWD);
  endfunction : on_w

  function automatic logic [3:0] dec_w(input logic u, input logic mdn, input logic p, input logic fast);
    if (u) return GATE_OFF;
    return (fast && !mdn) ? (p ? GATE_FAST_REV : GATE_FAST_FWD) : GATE_SLOW;
  endfunction : dec_w

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic summarize();
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // Reference model: current codes and pin ownership follow the mode one clock later.
  always @(negedge mclk) begin
    if (sys_rst) begin
      exp_q.delete();
    end else begin
      if (exp_q.size() > 0) begin
        exp_w = exp_q.pop_front();
        check(dac_code_a, exp_w[3:0]);
        check(dac_code_b, exp_w[7:4]);
        check({2'h0, fault_oe, serial_disable}, exp_w[11:8]);
      end
      exp_q.push_back(serial_port_select ? {20'h0, 4'h0, ~sdac, sdac} :
                      {20'h0, 4'h3, DAC_FULL_SCALE, DAC_FULL_SCALE});
    end
  end

  initial begin
    tick(40000);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(32'h648e));
    tick(20);
    sys_rst <= 1'b0;
    tick(3);
    #1;
    check(dac_code_a, DAC_FULL_SCALE);
    check(dac_code_b, DAC_FULL_SCALE);
    check({2'h0, fault_oe, serial_disable}, 4'h3);
    // Chopper clock stopped: only polarity changes restart the bridges.
    for (int i = 0; i < 8; i++) begin
      tick(1);
      unipolar_mode <= i[0];
      blank_sel <= 2'($urandom);
      st <= 2'h0;
      cmd[3:0] <= {2'($urandom), ~cmd[1:0]};
      tick(8);
      #1;
      check(ga, on_w(unipolar_mode, cmd[0]));
      check(gb, on_w(unipolar_mode, cmd[1]));
      tick(1);
      st <= 2'h3;
      tick(45);
      #1;
      check(ga, dec_w(unipolar_mode, cmd[2], cmd[0], 1'b1));
      check(gb, dec_w(unipolar_mode, cmd[3], cmd[1], 1'b1));
      tick(260);
      #1;
      check(ga, dec_w(unipolar_mode, cmd[2], cmd[0], 1'b0));
      check(gb, dec_w(unipolar_mode, cmd[3], cmd[1], 1'b0));
    end
    tick(1);
    chop_run <= 1'b1;
    ga_p = ga;
    gb_p = gb;
    for (int n = 0; n < 1000; n++) begin
      tick(1);
      #1;
      if (ga !== ga_p && ga === on_w(unipolar_mode, cmd[0])) check({3'h0, chop_clk_ext}, 4'h1);
      if (gb !== gb_p && gb === on_w(unipolar_mode, cmd[1])) check({3'h0, chop_clk_ext}, 4'h0);
      ga_p = ga;
      gb_p = gb;
    end
    // Internal oscillator: bridge A restarts every full period, bridge B half a period later.
    tick(1);
    osc_external <= 1'b0;
    tick(1000);
    #1;
    ga_p = ga;
    gb_p = gb;
    for (int n = 0; n < 2200; n++) begin
      tick(1);
      #1;
      if (ga !== ga_p && ga === on_w(unipolar_mode, cmd[0])) begin
        if (t_a >= 0) check({3'h0, n - t_a == 2 * CHOP_HALF_CYC}, 4'h1);
        t_a = n;
      end
      if (gb !== gb_p && gb === on_w(unipolar_mode, cmd[1]) && t_a >= 0) begin
        check({3'h0, n - t_a == CHOP_HALF_CYC}, 4'h1);
      end
      ga_p = ga;
      gb_p = gb;
    end
    tick(1);
    osc_external <= 1'b1;
    tick(1);
    st <= 2'h0;
    for (int k = 0; k < 3; k++) begin
      tick(1);
      oc <= 3'h1 << k;
      tick(1200);
      #1;
      check({1'b0, oc_flags}, {1'b0, 3'h1 << k});
      check({3'h0, fault_out}, 4'h1);
      check(k == 1 ? gb : ga, GATE_OFF);
      tick(1);
      oc <= 3'h0;
      cmd[4] <= 1'b1;
      tick(6);
      #1;
      check({1'b0, oc_flags}, 4'h0);
      check({3'h0, fault_out}, 4'h0);
      check(ga | gb, GATE_OFF);
      check({3'h0, standby_active}, 4'h1);
      tick(1);
      cmd[4] <= 1'b0;
    end
    over_temp <= 1'b1;
    tick(2);
    #1;
    check({3'h0, fault_out}, 4'h1);
    tick(1);
    over_temp <= 1'b0;
    cmd[5] <= 1'b1;
    sdac <= 4'($urandom);
    tick(4);
    #1;
    check(dac_code_a, sdac);
    check(dac_code_b, ~sdac);
    check({3'h0, fault_oe}, 4'h0);
    summarize();
  end
endmodule : test_sbc_bridge_ctrl
